// File: rtl/wsc_pkg.sv
// Purpose: Constants for the write strobe control host block
// Assumes: Channel clock counted in whole clocks
// Notes: Table rows indexed by frequency band, 0 = lowest band
package wsc_pkg;
   localparam int NUM_BANDS = 8;
   localparam int BAND_W = 3;
   localparam int CNT_W = 6;
   localparam logic [0:0] MODE_READ_BASED = 1'h0;
   localparam logic [0:0] MODE_WINDOW = 1'h1;
   localparam logic [0:0] WL_SET_A = 1'h0;
   localparam logic [0:0] WL_SET_B = 1'h1;
   // Write latency per band, set A and set B
   localparam logic [5:0] WL_A [NUM_BANDS] = '{6'h04, 6'h06, 6'h08, 6'h0A,
      6'h0C, 6'h0E, 6'h10, 6'h12};
   localparam logic [5:0] WL_B [NUM_BANDS] = '{6'h04, 6'h08, 6'h0C, 6'h12,
      6'h16, 6'h1A, 6'h1E, 6'h22};
   // Latest strobe on point after a write, in clocks
   localparam logic [5:0] ON_A [NUM_BANDS] = '{6'h00, 6'h00, 6'h00, 6'h04,
      6'h04, 6'h06, 6'h06, 6'h08};
   localparam logic [5:0] ON_B [NUM_BANDS] = '{6'h00, 6'h00, 6'h06, 6'h0C,
      6'h0E, 6'h12, 6'h14, 6'h18};
   // Least hold after the last write, in clocks
   localparam logic [5:0] OFF_A [NUM_BANDS] = '{6'h0F, 6'h12, 6'h15, 6'h18,
      6'h1B, 6'h1E, 6'h21, 6'h24};
   localparam logic [5:0] OFF_B [NUM_BANDS] = '{6'h0F, 6'h14, 6'h19, 6'h20,
      6'h25, 6'h2A, 6'h2F, 6'h34};
   typedef enum logic [1:0] {
      WSC_IDLE = 2'b00,
      WSC_ARMED = 2'b01,
      WSC_DIFF = 2'b10
   } wsc_state_t;
endpackage : wsc_pkg

// File: rtl/wsc_strobe_ctrl.sv
// Purpose: Host side write strobe parking and window control
// Assumes: Link clock sampled by core clock; commands arrive from logic
// Notes: Drives strobe pair enables; burst toggling comes from write path
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Host supports read-based parking or on/off window strobe control.
// - Read-based: on write, leave complement-high parking, go differential.
// - Read-based: after postamble, park complement high while CKE high.
// - Clock enable low: strobe pair left undriven, any state allowed.
// - Parking not required during read strobe or read/write handover.
// - Window: pair differential no later than on-deadline after write.
// - Window: pair differential for hold window after last write.
// - Window rule skipped during reads, postamble and turnarounds.
// - Burst toggling counts as differential; no extra drive needed then.
// - Exempt: ODT off max(0,WL-on+turnaround-preamble-n); ODT on turnaround.
// - Strobe control never changes command spacing; training timing wins.
// - ODT on: window inside ODT latencies; ODT off: exemption applies.
// - Turnaround time used only for exemption computation.
module wsc_strobe_ctrl
   import wsc_pkg::*;
#(
   parameter int TURNAROUND_CLK = 2,
   parameter int PREAMBLE_CLK = 2
)
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_link_clk,
   input wire logic i_cke,
   input wire logic i_mode,
   input wire logic i_wl_set,
   input wire logic [wsc_pkg::BAND_W-1:0] i_band,
   input wire logic i_odt_en,
   input wire logic [wsc_pkg::CNT_W-1:0] i_rtw_extra,
   input wire logic i_wr_cmd,
   input wire logic i_rd_cmd,
   input wire logic i_burst_active,
   input wire logic i_rd_active,
   input wire logic i_turnaround,
   output logic o_dqs_t,
   output logic o_dqs_c,
   output logic o_dqs_oe,
   output logic o_window_open,
   output logic o_exempt,
   output logic [wsc_pkg::CNT_W-1:0] o_exempt_len
);
   import wsc_pkg::*;

   // Counters are CNT_W wide; larger values would wrap the exemption sum
   if (TURNAROUND_CLK < 0 || TURNAROUND_CLK > 31 ||
       PREAMBLE_CLK < 0 || PREAMBLE_CLK > 31)
   begin : g_bad_param
      $error("wsc_strobe_ctrl: turnaround or preamble out of range");
   end

   localparam logic [CNT_W-1:0] TA_CLK = CNT_W'(TURNAROUND_CLK);
   localparam logic [CNT_W-1:0] PRE_CLK = CNT_W'(PREAMBLE_CLK);
   localparam logic [CNT_W-1:0] ONE = 6'h01;
   localparam logic [CNT_W-1:0] ZERO = 6'h00;

   // Two-flop sync of link clock and clock enable pins
   logic lk_s1, lk_s2, lk_d, ck_s1, ck_s2;
   logic next_lk_s1, next_lk_s2, next_lk_d, next_ck_s1, next_ck_s2;
   always_comb
   begin
      next_lk_s1 = i_link_clk;
      next_lk_s2 = lk_s1;
      next_lk_d = lk_s2;
      next_ck_s1 = i_cke;
      next_ck_s2 = ck_s1;
   end
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         lk_s1 <= 1'h0;
         lk_s2 <= 1'h0;
         lk_d <= 1'h0;
         ck_s1 <= 1'h0;
         ck_s2 <= 1'h0;
      end
      else
      begin
         lk_s1 <= next_lk_s1;
         lk_s2 <= next_lk_s2;
         lk_d <= next_lk_d;
         ck_s1 <= next_ck_s1;
         ck_s2 <= next_ck_s2;
      end
   end
   // Windows are counted in link clocks, so count rising edges only
   logic lk_rise;
   assign lk_rise = lk_s2 && !lk_d;

   // Table lookup by band and latency set
   logic [CNT_W-1:0] on_dl, hold_win, wl;
   always_comb
   begin
      on_dl = (i_wl_set == WL_SET_B) ? ON_B[i_band] : ON_A[i_band];
      hold_win = (i_wl_set == WL_SET_B) ? OFF_B[i_band] : OFF_A[i_band];
      wl = (i_wl_set == WL_SET_B) ? WL_B[i_band] : WL_A[i_band];
   end

   // Exemption length; turnaround only feeds this sum
   // Wide sums keep the subtraction from wrapping before the clamp
   logic [CNT_W+1:0] ex_pos, ex_neg;
   logic [CNT_W-1:0] next_exempt_len;
   always_comb
   begin
      ex_pos = {2'h0, wl} + {2'h0, TA_CLK};
      ex_neg = {2'h0, on_dl} + {2'h0, PRE_CLK} + {2'h0, i_rtw_extra};
      if (i_odt_en)
         next_exempt_len = TA_CLK;
      else if (ex_pos > ex_neg)
         next_exempt_len = CNT_W'(ex_pos - ex_neg);
      else
         next_exempt_len = ZERO;
   end

   // Window state: armed counts to on-deadline, diff counts hold window
   wsc_state_t state, next_state;
   logic [CNT_W-1:0] on_cnt, hold_cnt, ex_cnt;
   logic [CNT_W-1:0] next_on_cnt, next_hold_cnt, next_ex_cnt;
   always_comb
   begin
      next_state = state;
      next_on_cnt = on_cnt;
      next_hold_cnt = hold_cnt;
      next_ex_cnt = ex_cnt;
      // Exemption runs from a read or turnaround, refreshed each read
      if (i_rd_cmd || i_turnaround)
         next_ex_cnt = next_exempt_len;
      else if (lk_rise && ex_cnt != ZERO)
         next_ex_cnt = ex_cnt - ONE;
      unique case (state)
         WSC_IDLE:
         begin
            if (i_wr_cmd)
            begin
               next_state = (on_dl == ZERO) ? WSC_DIFF : WSC_ARMED;
               next_on_cnt = on_dl;
               next_hold_cnt = hold_win;
            end
         end
         WSC_ARMED:
         begin
            if (i_wr_cmd)
               next_hold_cnt = hold_win;
            if (lk_rise)
            begin
               next_on_cnt = on_cnt - ONE;
               // Reload wins over a same-cycle link edge
               next_hold_cnt = i_wr_cmd ? hold_win : hold_cnt - ONE;
               if (on_cnt <= ONE)
                  next_state = WSC_DIFF;
            end
         end
         WSC_DIFF:
         begin
            // Hold restarts from the last write
            if (i_wr_cmd)
               next_hold_cnt = hold_win;
            else if (lk_rise && hold_cnt != ZERO)
               next_hold_cnt = hold_cnt - ONE;
            else if (hold_cnt == ZERO)
               next_state = WSC_IDLE;
         end
         default:
            next_state = WSC_IDLE;
      endcase
      // Leaving window mode drops any window in flight
      if (i_mode != MODE_WINDOW)
         next_state = WSC_IDLE;
   end
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         state <= WSC_IDLE;
         on_cnt <= 6'h00;
         hold_cnt <= 6'h00;
         ex_cnt <= 6'h00;
      end
      else
      begin
         state <= next_state;
         on_cnt <= next_on_cnt;
         hold_cnt <= next_hold_cnt;
         ex_cnt <= next_ex_cnt;
      end
   end

   // Strobe pin drive: bursts own the pins while toggling
   logic exempt, next_dqs_t, next_dqs_c, next_dqs_oe, next_exempt;
   logic dqs_t_q, dqs_c_q, dqs_oe_q, exempt_q;
   logic [CNT_W-1:0] exempt_len_q;
   assign exempt = i_rd_active || i_turnaround || (ex_cnt != ZERO);
   always_comb
   begin
      next_dqs_t = 1'h0;
      next_dqs_c = 1'h1;
      next_dqs_oe = 1'h0;
      next_exempt = exempt;
      // Exemption count frees the pair in window mode only; parking must
      // resume as soon as a read or handover ends
      if (!ck_s2)
         next_dqs_oe = 1'h0;
      else if (i_rd_active || i_turnaround || i_burst_active)
         next_dqs_oe = 1'h0;
      else if (i_mode == MODE_READ_BASED)
         next_dqs_oe = 1'h1;
      else if (ex_cnt != ZERO)
         next_dqs_oe = 1'h0;
      else if (state == WSC_DIFF)
         next_dqs_oe = 1'h1;
      else if (i_wr_cmd || state == WSC_ARMED)
         next_dqs_oe = 1'h1;
   end
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         dqs_t_q <= 1'h0;
         dqs_c_q <= 1'h1;
         dqs_oe_q <= 1'h0;
         exempt_q <= 1'h0;
         exempt_len_q <= 6'h00;
      end
      else
      begin
         dqs_t_q <= next_dqs_t;
         dqs_c_q <= next_dqs_c;
         dqs_oe_q <= next_dqs_oe;
         exempt_q <= next_exempt;
         exempt_len_q <= next_exempt_len;
      end
   end
   assign o_dqs_t = dqs_t_q;
   assign o_dqs_c = dqs_c_q;
   assign o_dqs_oe = dqs_oe_q;
   assign o_exempt = exempt_q;
   assign o_exempt_len = exempt_len_q;
   assign o_window_open = (state == WSC_DIFF);

   // Checks on the drive decisions, window arming, hold reload and exemption length
   property p_cke_low;
      @(posedge i_core_clk) disable iff (i_rst)
      !ck_s2 |=> !o_dqs_oe;
   endproperty
   a_cke_low: assert property (p_cke_low)
      else $error("drive with cke low");
   property p_exempt_nodrive;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_rd_active || i_turnaround) |=> !o_dqs_oe;
   endproperty
   a_exempt_nodrive: assert property (p_exempt_nodrive)
      else $error("strobe driven during read");
   property p_park;
      @(posedge i_core_clk) disable iff (i_rst)
      (ck_s2 && !i_rd_active && !i_turnaround && !i_burst_active &&
       i_mode == MODE_READ_BASED)
      |=> (o_dqs_oe && o_dqs_c && !o_dqs_t);
   endproperty
   a_park: assert property (p_park) else $error("complement not parked");
   property p_diff_drive;
      @(posedge i_core_clk) disable iff (i_rst)
      (state == WSC_DIFF && ck_s2 && !exempt && !i_burst_active)
      |=> o_dqs_oe;
   endproperty
   a_diff_drive: assert property (p_diff_drive)
      else $error("window not driven");
   property p_wr_arms;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_mode == MODE_WINDOW && state == WSC_IDLE && i_wr_cmd)
      |=> (state != WSC_IDLE);
   endproperty
   a_wr_arms: assert property (p_wr_arms) else $error("write not armed");
   property p_odt_ex;
      @(posedge i_core_clk) disable iff (i_rst)
      i_odt_en |=> (o_exempt_len == TA_CLK);
   endproperty
   a_odt_ex: assert property (p_odt_ex)
      else $error("odt exemption wrong");
   property p_burst;
      @(posedge i_core_clk) disable iff (i_rst)
      i_burst_active |=> !o_dqs_oe;
   endproperty
   a_burst: assert property (p_burst) else $error("drive in burst");
   property p_hold_reload;
      @(posedge i_core_clk) disable iff (i_rst)
      (state == WSC_DIFF && i_wr_cmd && i_mode == MODE_WINDOW)
      |=> (hold_cnt == $past(hold_win));
   endproperty
   a_hold_reload: assert property (p_hold_reload)
      else $error("hold not reloaded");
   c_window: cover property (@(posedge i_core_clk) state == WSC_DIFF);
   c_armed: cover property (@(posedge i_core_clk) state == WSC_ARMED);
   c_reload: cover property (@(posedge i_core_clk)
      state == WSC_DIFF && i_wr_cmd);
   c_exempt: cover property (@(posedge i_core_clk) ex_cnt != ZERO);
   c_park: cover property (@(posedge i_core_clk) o_dqs_oe && !i_mode);
endmodule : wsc_strobe_ctrl
`default_nettype wire

// File: tb/wsc_dev_model.sv
// Purpose: Memory device side of the write strobe pair
// Assumes: Pair and commands sampled on the core clock
// Notes: Counts writes that find the pair undriven outside exemptions
`timescale 1ns/1ps
`default_nettype none
module wsc_dev_model
(
   input wire logic i_core_clk,
   input wire logic i_cke,
   input wire logic i_wr_cmd,
   input wire logic i_dqs_t,
   input wire logic i_dqs_c,
   input wire logic i_dqs_oe,
   input wire logic i_rd_active,
   input wire logic i_turnaround,
   input wire logic i_burst_active,
   input wire logic [2:0] i_odt_field,
   output logic o_term_on,
   output logic o_pin_t,
   output logic o_pin_c,
   output var int o_viol
);
   logic [1:0] wr_dly = 2'h0;
   initial o_viol = 0;
   initial o_pin_t = 1'b0;
   // A released pair floats, so show a changing level, never the last one
   always @(posedge i_core_clk)
   begin
      wr_dly <= {wr_dly[0], i_wr_cmd};
      o_pin_t <= i_dqs_oe ? i_dqs_t : ~o_pin_t;
      o_pin_c <= i_dqs_oe ? i_dqs_c : o_pin_t;
      // Reads, handovers, bursts and clock enable low excuse the pair
      if (wr_dly[1] && i_cke && !i_rd_active && !i_turnaround
         && !i_burst_active && !(i_dqs_oe && i_dqs_t != i_dqs_c))
         o_viol <= o_viol + 1;
   end
   // Termination only while a write runs with a nonzero setting
   assign o_term_on = (i_odt_field != 3'h0) && wr_dly[1];
endmodule : wsc_dev_model
`default_nettype wire

// File: tb/write_strobe_control_tb.sv
// Purpose: Self-checking bench for the write strobe control block
// Assumes: Link clock runs free at 320 ns, core clock at 40 ns
// Notes: Longest hold is 52 link clocks, so no count is shortened
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module write_strobe_control_tb;
   import wsc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, lclk = 1'b0, cke = 1'b0, mode = 1'b0;
   logic wl_set = 1'b0, odt = 1'b0, wr = 1'b0, rd = 1'b0;
   logic burst = 1'b0, rda = 1'b0, ta = 1'b0;
   logic [2:0] band = 3'h0;
   logic [5:0] extra = 6'h00;
   logic dqs_t, dqs_c, oe, win, ex, term, pin_t, pin_c;
   logic [5:0] ex_len;
   logic [31:0] seed = 32'h334ECD37, r;
   int err_total = 0, n_compared = 0, viol, cyc = 0, e;
   initial forever #20 clk = ~clk;
   initial forever #160 lclk = ~lclk;
   wsc_strobe_ctrl #(.TURNAROUND_CLK(2), .PREAMBLE_CLK(2)) dut (
      .i_core_clk(clk), .i_rst(rst), .i_link_clk(lclk), .i_cke(cke),
      .i_mode(mode), .i_wl_set(wl_set), .i_band(band), .i_odt_en(odt),
      .i_rtw_extra(extra), .i_wr_cmd(wr), .i_rd_cmd(rd),
      .i_burst_active(burst), .i_rd_active(rda), .i_turnaround(ta),
      .o_dqs_t(dqs_t), .o_dqs_c(dqs_c), .o_dqs_oe(oe),
      .o_window_open(win), .o_exempt(ex), .o_exempt_len(ex_len));
   wsc_dev_model dev (.i_core_clk(clk), .i_cke(cke), .i_wr_cmd(wr),
      .i_dqs_t(dqs_t), .i_dqs_c(dqs_c), .i_dqs_oe(oe), .i_rd_active(rda),
      .i_turnaround(ta), .i_burst_active(burst),
      .i_odt_field({2'h0, odt}), .o_term_on(term),
      .o_pin_t(pin_t), .o_pin_c(pin_c), .o_viol(viol));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Exemption: ODT off clamps at zero, ODT on is the turnaround time
   function automatic int exempt_of(logic s, logic [2:0] b, logic o, int n);
      int v;
      v = s ? int'(WL_B[b]) - int'(ON_B[b]) : int'(WL_A[b]) - int'(ON_A[b]);
      v = v + 2 - 2 - n;
      if (o)
         v = 2;
      return v < 0 ? 0 : v;
   endfunction : exempt_of
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // Extra core cycles cover the two-flop sampling of the link clock
   task automatic lrise(int n);
      repeat (n) @(posedge lclk);
      tick(4);
   endtask : lrise
   task automatic finish_test();
      `CHK(viol, 0)
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // Cut a hang short well beyond the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         finish_test();
      end
   end
   initial
   begin
      tick(16);
      rst <= 1'b0;
      cke <= 1'b1;
      tick(6);
      `CHK({oe, dqs_t, dqs_c}, 3'b101)
      `CHK({pin_t, pin_c}, 2'b01)
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      burst <= 1'b1;
      tick(8);
      burst <= 1'b0;
      tick(4);
      `CHK({oe, dqs_t, dqs_c}, 3'b101)
      rda <= 1'b1;
      tick(3);
      `CHK(oe, 1'b0)
      rda <= 1'b0;
      ta <= 1'b1;
      tick(3);
      `CHK(oe, 1'b0)
      ta <= 1'b0;
      cke <= 1'b0;
      tick(5);
      `CHK(oe, 1'b0)
      cke <= 1'b1;
      tick(5);
      `CHK(oe, 1'b1)
      // Exemption length, deepest row and clamp to zero first
      for (int i = 0; i < 12; i++)
      begin
         r = i == 0 ? 32'h0F : i == 1 ? 32'h1E0 : rnd();
         wl_set <= r[0];
         band <= r[3:1];
         odt <= r[4];
         extra <= {2'h0, r[8:5]};
         tick(1);
         rd <= 1'b1;
         tick(1);
         rd <= 1'b0;
         tick(3);
         e = exempt_of(r[0], r[3:1], r[4], int'(r[8:5]));
         `CHK(ex_len, e[5:0])
         if (e > 2)
            `CHK(ex, 1'b1)
         lrise(40);
      end
      mode <= 1'b1;
      // Window mode: second write reloads the hold
      for (int i = 0; i < 6; i++)
      begin
         r = i == 0 ? 32'h0F : rnd();
         wl_set <= r[0];
         band <= r[3:1];
         tick(2);
         wr <= 1'b1;
         tick(1);
         wr <= 1'b0;
         e = r[0] ? int'(ON_B[r[3:1]]) : int'(ON_A[r[3:1]]);
         tick(2);
         `CHK({oe, win}, {1'b1, e == 0})
         lrise(10);
         wr <= 1'b1;
         tick(1);
         wr <= 1'b0;
         e = r[0] ? int'(OFF_B[r[3:1]]) : int'(OFF_A[r[3:1]]);
         lrise(e - 1);
         `CHK({oe, win}, 2'b11)
         lrise(4);
         `CHK(oe, 1'b0)
      end
      finish_test();
   end
endmodule : write_strobe_control_tb
`default_nettype wire
